// >>> common/rsc_pkg.sv
// constants and types for the receive statistics counter tail
// How it works
// - frame starts kept 64-bit, low/high words
// - count CRC-bad frames 64..max, high readable
// - count data-carrying symbols from PHY
// - count accepted frame starts, 64-bit
// - count accepted data-carrying symbols, 64-bit
// - count packets aborted for excess length
// - count blocks carrying media error codes
// - count received runt packets
// - count each pulse on fcs error output, except in adapter mode
package rsc_pkg;

  // apb geometry: word index sits above the byte lane bits
  localparam int APB_ADDR_W = 12;
  localparam int IDX_LSB    = 2;
  localparam int IDX_MSB    = 11;
  localparam int IDX_W      = 10;

  // word indices; byte address is four times the index
  localparam logic [9:0] IDX_CRC_HI   = 10'h2a9;
  localparam logic [9:0] IDX_ST_LO    = 10'h2aa;
  localparam logic [9:0] IDX_ST_HI    = 10'h2ab;
  localparam logic [9:0] IDX_DB_LO    = 10'h2ac;
  localparam logic [9:0] IDX_DB_HI    = 10'h2ad;
  localparam logic [9:0] IDX_FST_LO   = 10'h2ae;
  localparam logic [9:0] IDX_FST_HI   = 10'h2af;
  localparam logic [9:0] IDX_FDB_LO   = 10'h2b0;
  localparam logic [9:0] IDX_FDB_HI   = 10'h2b1;
  localparam logic [9:0] IDX_LONG     = 10'h2b2;
  localparam logic [9:0] IDX_RSVD_A   = 10'h2b3;
  localparam logic [9:0] IDX_EBLK     = 10'h2b4;
  localparam logic [9:0] IDX_RSVD_B   = 10'h2b5;
  localparam logic [9:0] IDX_RUNT     = 10'h2b6;
  localparam logic [9:0] IDX_RSVD_C   = 10'h2b7;
  localparam logic [9:0] IDX_FCS      = 10'h2b8;
  localparam logic [9:0] IDX_CTRL     = 10'h2c0;
  localparam logic [9:0] IDX_MAXLEN   = 10'h2c1;

  // control word fields
  localparam int CTRL_ADAPT_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0001;

  // frame length limits in bytes
  localparam logic [15:0] MIN_FRAME_LEN = 16'h0040;
  localparam logic [15:0] MAXLEN_RST    = 16'h05ee;
  localparam int          MAXLEN_W      = 16;

  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // per-cycle events from the receive datapath, same clock
  typedef struct packed {
    logic        frame_start;  // a frame start was seen
    logic        start_accept; // the mac accepted that start
    logic        blk_valid;    // a full symbol crossed phy to mac
    logic        blk_has_data; // that symbol held some data
    logic        blk_accept;   // the mac accepted that symbol
    logic        frame_end;    // a frame finished this cycle
    logic        crc_bad;      // finished frame failed its crc
    logic [15:0] frame_len;    // byte length of finished frame
    logic        too_long;     // packet aborted for length
    logic        err_block;    // block carried an error code
    logic        runt;         // runt packet seen
  } rsc_rx_ev_t;

endpackage

// >>> logic/rsc_counter.sv
// free-running event counter with synchronous clear
`timescale 1ns/1ps
module rsc_counter #(
  parameter int WIDTH = 32
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic             clear,
  input  wire logic             inc,
  output logic [WIDTH-1:0]      count
);

  // wraps at full scale; a clear that meets an event keeps
  // that event so nothing is lost across the clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
    end else if (clear) begin
      count <= inc ? WIDTH'(1) : '0;
    end else if (inc) begin
      count <= count + WIDTH'(1);
    end
  end

endmodule

// >>> logic/rsc_rx_stats.sv
// receive statistics counter tail with an apb register slave
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
module rsc_rx_stats (
  input  wire logic                       mclk,
  input  wire logic                       resetn,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [rsc_pkg::APB_ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  // events from the receive datapath
  input  wire rsc_pkg::rsc_rx_ev_t        rx_ev,
  // pulse per frame that ends with a bad check sequence
  output logic                            rx_fcs_error
);

  // word index of the current apb access
  logic [rsc_pkg::IDX_W-1:0] idx;

  // software controls
  logic [31:0]               ctrl;        // adapter mode bit
  logic [rsc_pkg::MAXLEN_W-1:0] max_len;  // largest legal frame
  logic                      clear_all;   // one-cycle clear pulse

  // apb access completes on this cycle
  logic                      acc_done;
  logic                      wr_done;

  // counter increments
  logic                      inc_crc;
  logic                      inc_st;
  logic                      inc_db;
  logic                      inc_fst;
  logic                      inc_fdb;
  logic                      inc_fcs;

  // counter values
  logic [63:0]               cnt_crc;
  logic [63:0]               cnt_st;
  logic [63:0]               cnt_db;
  logic [63:0]               cnt_fst;
  logic [63:0]               cnt_fdb;
  logic [31:0]               cnt_long;
  logic [31:0]               cnt_eblk;
  logic [31:0]               cnt_runt;
  logic [31:0]               cnt_fcs;

  // read mux results
  logic [31:0]               next_prdata;
  logic                      next_pslverr;

  // byte lane bits are ignored; every register is one word
  assign idx = paddr[rsc_pkg::IDX_MSB:rsc_pkg::IDX_LSB];

  // pready is registered, so every access takes one wait state
  // writes land on the edge that samples ready high, never before
  assign acc_done = psel & penable & pready;
  assign wr_done  = acc_done & pwrite;

  // length window check, used only by the crc statistic
  function automatic logic len_in_window(
    input logic [rsc_pkg::MAXLEN_W-1:0] len,
    input logic [rsc_pkg::MAXLEN_W-1:0] lim
  );
    len_in_window = (len >= rsc_pkg::MIN_FRAME_LEN) && (len <= lim);
  endfunction

  // a block counts only when it is a full symbol holding data
  function automatic logic data_block(
    input rsc_pkg::rsc_rx_ev_t ev
  );
    data_block = ev.blk_valid & ev.blk_has_data;
  endfunction

  // event qualification
  assign inc_crc = rx_ev.frame_end & rx_ev.crc_bad
                 & len_in_window(rx_ev.frame_len, max_len);
  // every start counts, taken by the mac or not
  assign inc_st  = rx_ev.frame_start;
  assign inc_db  = data_block(rx_ev);
  assign inc_fst = rx_ev.frame_start & rx_ev.start_accept;
  // an accepted symbol must still carry data to count
  assign inc_fdb = data_block(rx_ev) & rx_ev.blk_accept;
  // with adapters fitted the fcs pulse is not the client view,
  // so the counter holds still in that mode
  assign inc_fcs = rx_fcs_error
                 & ~ctrl[rsc_pkg::CTRL_ADAPT_BIT];

  // apb handshake: ready rises in the second access cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
    end else begin
      // falls after one cycle so each access answers once
      pready <= psel & penable & ~pready;
    end
  end

  // read data and error are registered with ready
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prdata  <= rsc_pkg::ZERO_WORD;
      pslverr <= 1'b0;
    end else if (psel & penable & ~pready) begin
      prdata  <= pwrite ? rsc_pkg::ZERO_WORD : next_prdata;
      pslverr <= next_pslverr;
    end else begin
      // idle cycles read zero so no stale word lingers
      prdata  <= rsc_pkg::ZERO_WORD;
      pslverr <= 1'b0;
    end
  end

  // read mux; counters accept and drop writes without error
  always_comb begin
    next_prdata  = rsc_pkg::ZERO_WORD;
    next_pslverr = 1'b0;
    case (idx)
      rsc_pkg::IDX_CRC_HI: begin
        next_prdata = cnt_crc[63:32];
      end
      rsc_pkg::IDX_ST_LO: begin
        next_prdata = cnt_st[31:0];
      end
      rsc_pkg::IDX_ST_HI: begin
        next_prdata = cnt_st[63:32];
      end
      rsc_pkg::IDX_DB_LO: begin
        next_prdata = cnt_db[31:0];
      end
      rsc_pkg::IDX_DB_HI: begin
        next_prdata = cnt_db[63:32];
      end
      rsc_pkg::IDX_FST_LO: begin
        next_prdata = cnt_fst[31:0];
      end
      rsc_pkg::IDX_FST_HI: begin
        next_prdata = cnt_fst[63:32];
      end
      rsc_pkg::IDX_FDB_LO: begin
        next_prdata = cnt_fdb[31:0];
      end
      rsc_pkg::IDX_FDB_HI: begin
        next_prdata = cnt_fdb[63:32];
      end
      rsc_pkg::IDX_LONG: begin
        next_prdata = cnt_long;
      end
      rsc_pkg::IDX_EBLK: begin
        next_prdata = cnt_eblk;
      end
      rsc_pkg::IDX_RUNT: begin
        next_prdata = cnt_runt;
      end
      rsc_pkg::IDX_FCS: begin
        next_prdata = cnt_fcs;
      end
      rsc_pkg::IDX_RSVD_A,
      rsc_pkg::IDX_RSVD_B,
      rsc_pkg::IDX_RSVD_C: begin
        next_prdata = rsc_pkg::ZERO_WORD;
      end
      rsc_pkg::IDX_CTRL: begin
        // only the adapter bit is stored; the clear strobe reads 0
        next_prdata = ctrl;
      end
      rsc_pkg::IDX_MAXLEN: begin
        // upper half of the word reads as zero
        next_prdata = {16'h0000, max_len};
      end
      default: begin
        // outside the bank: zero data and a slave error
        next_prdata  = rsc_pkg::ZERO_WORD;
        next_pslverr = 1'b1;
      end
    endcase
  end

  // control word; only writable bits are stored
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= rsc_pkg::CTRL_RST;
    end else if (wr_done && idx == rsc_pkg::IDX_CTRL) begin
      ctrl <= pwdata & rsc_pkg::CTRL_MASK;
    end
  end

  // clear bit is a strobe and never reads back as one
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      clear_all <= 1'b0;
    end else begin
      clear_all <= wr_done && idx == rsc_pkg::IDX_CTRL
                && pwdata[rsc_pkg::CTRL_CLEAR_BIT];
    end
  end

  // largest legal frame size for the crc length window
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      max_len <= rsc_pkg::MAXLEN_RST;
    end else if (wr_done && idx == rsc_pkg::IDX_MAXLEN) begin
      max_len <= pwdata[rsc_pkg::MAXLEN_W-1:0];
    end
  end

  // fcs error output: one pulse per bad frame end, from a flop
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rx_fcs_error <= 1'b0;
    end else begin
      // any length: unlike the crc statistic, no window applies
      rx_fcs_error <= rx_ev.frame_end & rx_ev.crc_bad;
    end
  end

  // 64-bit statistics; halves are read live, so software
  // should reread the high word if the low word wrapped
  // crc-bad frames inside the length window; high half mapped here
  rsc_counter #(.WIDTH(64)) u_crc (
    .mclk   (mclk),
    .resetn (resetn),
    .clear  (clear_all),
    .inc    (inc_crc),
    .count  (cnt_crc)
  );

  // every frame start seen
  rsc_counter #(.WIDTH(64)) u_st (
    .mclk   (mclk),
    .resetn (resetn),
    .clear  (clear_all),
    .inc    (inc_st),
    .count  (cnt_st)
  );

  // full symbols that carry data
  rsc_counter #(.WIDTH(64)) u_db (
    .mclk   (mclk),
    .resetn (resetn),
    .clear  (clear_all),
    .inc    (inc_db),
    .count  (cnt_db)
  );

  // frame starts the mac kept
  rsc_counter #(.WIDTH(64)) u_fst (
    .mclk   (mclk),
    .resetn (resetn),
    .clear  (clear_all),
    .inc    (inc_fst),
    .count  (cnt_fst)
  );

  // data symbols the mac kept
  rsc_counter #(.WIDTH(64)) u_fdb (
    .mclk   (mclk),
    .resetn (resetn),
    .clear  (clear_all),
    .inc    (inc_fdb),
    .count  (cnt_fdb)
  );

  // 32-bit statistics
  // packets cut for excess length
  rsc_counter #(.WIDTH(32)) u_long (
    .mclk   (mclk),
    .resetn (resetn),
    .clear  (clear_all),
    .inc    (rx_ev.too_long),
    .count  (cnt_long)
  );

  // blocks marked with media error codes
  rsc_counter #(.WIDTH(32)) u_eblk (
    .mclk   (mclk),
    .resetn (resetn),
    .clear  (clear_all),
    .inc    (rx_ev.err_block),
    .count  (cnt_eblk)
  );

  // runt packets
  rsc_counter #(.WIDTH(32)) u_runt (
    .mclk   (mclk),
    .resetn (resetn),
    .clear  (clear_all),
    .inc    (rx_ev.runt),
    .count  (cnt_runt)
  );

  // pulses on the fcs error output, held still in adapter mode
  rsc_counter #(.WIDTH(32)) u_fcs (
    .mclk   (mclk),
    .resetn (resetn),
    .clear  (clear_all),
    .inc    (inc_fcs),
    .count  (cnt_fcs)
  );

endmodule

// >>> verif/rsc_rx_stats_assertions.sv
// checker for the apb slave and fcs pulse of the counter tail
`timescale 1ns/1ps
module rsc_rx_stats_chk (
  input wire logic                       mclk,
  input wire logic                       resetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [rsc_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic [31:0]                pwdata,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire rsc_pkg::rsc_rx_ev_t        rx_ev,
  input wire logic                       rx_fcs_error
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // word index of the current transfer
  wire logic [9:0] idx = paddr[11:2];
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  wait_state_a: assert property (s_setup ##1 s_wait |=> pready)
    else $error("answer not after one wait state");
  ready_once_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  ready_cause_a: assert property
    (pready |-> psel && penable && $past(psel && penable))
    else $error("ready outside an access phase");
  rdata_idle_a: assert property
    (!pready |-> prdata == 32'h0000_0000)
    else $error("read data not zero while idle");
  rsvd_zero_a: assert property
    (pready && (idx == rsc_pkg::IDX_RSVD_A || idx == rsc_pkg::IDX_RSVD_B
     || idx == rsc_pkg::IDX_RSVD_C) |-> prdata == 32'h0000_0000 && !pslverr)
    else $error("reserved word not quiet zero");
  unmapped_err_a: assert property
    (pready && idx < rsc_pkg::IDX_CRC_HI |-> pslverr)
    else $error("unmapped word without error");
  fcs_pulse_a: assert property
    (rx_ev.frame_end && rx_ev.crc_bad |=> rx_fcs_error)
    else $error("fcs pulse missing");
  fcs_cause_a: assert property
    (rx_fcs_error |-> $past(rx_ev.frame_end && rx_ev.crc_bad))
    else $error("fcs pulse without bad frame");
endmodule
bind rsc_rx_stats rsc_rx_stats_chk u_chk (.mclk(mclk), .resetn(resetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_ev(rx_ev), .rx_fcs_error(rx_fcs_error));

// >>> verif/rsc_rx_src.sv
// behavioural receive datapath issuing event words, each held until the next send
`timescale 1ns/1ps
module rsc_rx_src (
  input  wire logic           mclk,
  output rsc_pkg::rsc_rx_ev_t rx_ev
);
  // quiet until the bench asks for an event
  initial rx_ev = '0;
  // one word per call; the word holds until the next send replaces it
  task automatic send(input rsc_pkg::rsc_rx_ev_t e);
    @(posedge mclk);
    rx_ev <= e;
  endtask
endmodule

// >>> verif/rsc_rx_stats_tb_top.sv
// self-checking bench for the receive statistics counter tail
`timescale 1ns/1ps
module rsc_rx_stats_tb_top;
  logic                          mclk = 1'b0;
  logic                          resetn = 1'b0;
  logic                          psel = 1'b0;
  logic                          penable = 1'b0;
  logic                          pwrite = 1'b0;
  logic [rsc_pkg::APB_ADDR_W-1:0] paddr = '0;
  logic [31:0]                   pwdata = 32'h0000_0000;
  logic [31:0]                   prdata;
  logic                          pready;
  logic                          pslverr;
  rsc_pkg::rsc_rx_ev_t           rx_ev;
  logic                          rx_fcs_error;
  logic [31:0]                   rd;  // data of last read
  logic                          err; // error flag of last transfer
  int                            n_fail = 0;
  int                            total_checks = 0;
  always #50 mclk = ~mclk;
  rsc_rx_stats DUT (.mclk(mclk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_ev(rx_ev),
    .rx_fcs_error(rx_fcs_error));
  rsc_rx_src src (.mclk(mclk), .rx_ev(rx_ev));
  // flags: start acc valid data bacc end crcbad long errblk runt
  function automatic rsc_pkg::rsc_rx_ev_t mk(input logic [9:0] f,
                                              input logic [15:0] n = '0);
    mk = {f[9:3], n, f[2:0]};
  endfunction
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // one apb transfer; request held until ready is seen at an edge
  task automatic apb(input logic wr, input logic [9:0] idx,
                     input logic [31:0] wd);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string what, input logic [9:0] idx,
                       input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    check(what, exp, rd);
  endtask
  // every counter word of the bank, reserved ones too, starts at zero
  task automatic t_reset();
    for (int i = 0; i < 16; i++) begin
      rdchk("reset word", rsc_pkg::IDX_CRC_HI + 10'(i), '0);
    end
  endtask
  // back-to-back events, including symbols without data or valid
  task automatic t_counts();
    src.send(mk(10'h3e5));
    src.send(mk(10'h2c3));
    src.send(mk(10'h3a1));
    src.send(mk(10'h064));
    src.send(mk(10'h000));
    rdchk("starts", rsc_pkg::IDX_ST_LO, 32'h0000_0003);
    rdchk("starts hi", rsc_pkg::IDX_ST_HI, '0);
    rdchk("blocks", rsc_pkg::IDX_DB_LO, 32'h0000_0002);
    rdchk("acc starts", rsc_pkg::IDX_FST_LO, 32'h0000_0002);
    rdchk("acc blocks", rsc_pkg::IDX_FDB_LO, 32'h0000_0001);
    rdchk("long", rsc_pkg::IDX_LONG, 32'h0000_0002);
    rdchk("err blocks", rsc_pkg::IDX_EBLK, 32'h0000_0001);
    rdchk("runts", rsc_pkg::IDX_RUNT, 32'h0000_0003);
  endtask
  // bad frames at 63/64/1518/1519 (only crc high word checked), then fcs frozen with adapters
  task automatic t_crc();
    src.send(mk(10'h018, 16'h003f));
    src.send(mk(10'h018, 16'h0040));
    src.send(mk(10'h018, 16'h05ee));
    src.send(mk(10'h018, 16'h05ef));
    src.send(mk(10'h010, 16'h0040));
    src.send(mk(10'h000));
    rdchk("crc high", rsc_pkg::IDX_CRC_HI, '0);
    rdchk("max len", rsc_pkg::IDX_MAXLEN,
          {16'h0000, rsc_pkg::MAXLEN_RST});
    rdchk("fcs", rsc_pkg::IDX_FCS, 32'h0000_0004);
    apb(1'b1, rsc_pkg::IDX_CTRL, 32'h0000_0001);
    rdchk("ctrl", rsc_pkg::IDX_CTRL, 32'h0000_0001);
    src.send(mk(10'h018, 16'h0040));
    src.send(mk(10'h000));
    rdchk("fcs frozen", rsc_pkg::IDX_FCS, 32'h0000_0004);
    apb(1'b1, rsc_pkg::IDX_CTRL, '0);
  endtask
  // writes to reserved and counter words change nothing
  task automatic t_rsvd();
    apb(1'b1, rsc_pkg::IDX_RSVD_C, 32'hffff_ffff);
    rdchk("reserved", rsc_pkg::IDX_RSVD_C, '0);
    apb(1'b1, rsc_pkg::IDX_ST_LO, 32'hffff_ffff);
    rdchk("starts kept", rsc_pkg::IDX_ST_LO, 32'h0000_0003);
    apb(1'b0, 10'h000, '0);
    check("unmapped", 32'h0000_0001, {31'h0, err});
  endtask
  // clear strobe; a start landing in the clear cycle survives it
  task automatic t_clear();
    fork
      apb(1'b1, rsc_pkg::IDX_CTRL, 32'h0000_0002);
      begin
        repeat (3) @(posedge mclk);
        src.send(mk(10'h200));
        src.send(mk(10'h000));
      end
    join
    rdchk("cleared", rsc_pkg::IDX_FST_LO, '0);
    rdchk("cleared blocks", rsc_pkg::IDX_DB_LO, '0);
    rdchk("set wins", rsc_pkg::IDX_ST_LO, 32'h0000_0001);
    rdchk("clear strobe", rsc_pkg::IDX_CTRL, '0);
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    t_reset();
    t_counts();
    t_crc();
    t_rsvd();
    t_clear();
    report_and_stop();
  end
endmodule
